// file: src/jtag_tap.sv
// boundary-scan test access port, oversampled on the system clock
// Operation
// - controller, paths and scan behaviour follow the 1990 test port standard
// - pin scan is refused while configuration runs; master must wait
// - instruction register is ten bits, shifted when the instruction path is chosen
// - sample/preload snapshots pins and preloads a pattern; analyzer uses it too (here the analyzer has its own arm and read instructions instead)
// - extest drives the pattern onto outputs and captures input pins
// - bypass puts one bit between serial input and output
// - user_signature_register puts the 32-bit user signature on the serial path
// - device_identity_register puts the identification word on the serial path
// - identity is version 4, part 16, maker 11, then one bit
// - version field sits in the most significant bits
// - identity least significant bit is always one
// - boundary register length is a per-device parameter
// - configuration instructions load the configuration through the port
// - analyzer instructions let the port watch internal operation
// - analyzer samples at full speed; results read back through the port
`timescale 1ns/1ps
`include "tap_consts.svh"
module jtag_tap
    import tap_pkg::*;
#(
    parameter int BSR_LEN = `BSR_LEN_DEFAULT,
    parameter logic [9:0] OPC_EXTEST = `OP_EXTEST,
    parameter logic [9:0] OPC_SAMPLE = `OP_SAMPLE,
    parameter logic [9:0] OPC_DEVICE_IDENTITY_REGISTER = `OP_DEVICE_IDENTITY_REGISTER,
    parameter logic [9:0] OPC_USER = `OP_USER_SIGNATURE_REGISTER,
    parameter logic [9:0] OPC_CFG = `OP_CFG_LOAD,
    parameter logic [9:0] OPC_ANA_RD = `OP_ANA_READ,
    parameter logic [9:0] OPC_ANA_ARM = `OP_ANA_ARM
) (
    input wire logic SYS_CLK,
    input wire logic RESET,
    input wire logic TCK,
    input wire logic TMS,
    input wire logic TDI,
    output logic TDO,
    output logic TDO_OE,
    input wire logic CONFIG_BUSY,
    input wire logic [BSR_LEN-1:0] PIN_IN,
    output logic [BSR_LEN-1:0] PIN_DRIVE,
    output logic EXTEST_EN,
    input wire logic [31:0] USER_SIG,
    output logic [7:0] CFG_DATA,
    output logic CFG_VALID,
    input wire logic CFG_READY,
    input wire logic [31:0] ANA_PROBE,
    output logic ANA_ARM
);
    localparam int DR_W = (BSR_LEN > 32) ? BSR_LEN : 32;
    localparam logic [31:0] ID_WORD = {`ID_VERSION, `ID_PART, `ID_MAKER, 1'b1};

    jtag_in_type sync1_reg;
    jtag_in_type sync2_reg;
    logic busy1_reg;
    logic busy2_reg;
    logic tck_prev_reg;
    logic tck_rise;
    logic tck_fall;

    tap_state_type state_reg, state_next;
    logic [9:0] ir_reg, ir_next;
    logic [9:0] ir_sh_reg, ir_sh_next;
    logic [DR_W-1:0] dr_reg, dr_next;
    logic [BSR_LEN-1:0] upd_reg, upd_next;
    logic tdo_reg, tdo_next;
    logic oe_reg, oe_next;
    logic [2:0] bit_cnt_reg, bit_cnt_next;
    cfg_byte_type pend_reg, pend_next;
    logic overrun_reg, overrun_next;
    logic [31:0] ana_snap_reg, ana_snap_next;
    logic arm_reg, arm_next;
    logic buf_in_ready;
    dr_sel_type sel;

    ////////////////////////////////////////////////////////////////////////
    // port pins and the busy strap come from other domains: two flops first
    always_ff @(posedge SYS_CLK)
    begin
        if (RESET)
        begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            busy1_reg <= 1'b0;
            busy2_reg <= 1'b0;
            tck_prev_reg <= 1'b0;
        end
        else
        begin
            sync1_reg <= '{tck: TCK, tms: TMS, tdi: TDI};
            sync2_reg <= sync1_reg;
            busy1_reg <= CONFIG_BUSY;
            busy2_reg <= busy1_reg;
            tck_prev_reg <= sync2_reg.tck;
        end
    end

    // edges of the test clock as one-cycle strobes
    assign tck_rise = sync2_reg.tck && !tck_prev_reg;
    assign tck_fall = !sync2_reg.tck && tck_prev_reg;

    ////////////////////////////////////////////////////////////////////////
    // controller transitions on tms at each rising test clock edge
    function automatic tap_state_type tap_step(tap_state_type s, logic m);
        case (s)
            ST_RESET: return m ? ST_RESET : ST_IDLE;
            ST_IDLE: return m ? ST_SEL_DR : ST_IDLE;
            ST_SEL_DR: return m ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: return m ? ST_EX1_DR : ST_SH_DR;
            ST_SH_DR: return m ? ST_EX1_DR : ST_SH_DR;
            ST_EX1_DR: return m ? ST_UPD_DR : ST_PAU_DR;
            ST_PAU_DR: return m ? ST_EX2_DR : ST_PAU_DR;
            ST_EX2_DR: return m ? ST_UPD_DR : ST_SH_DR;
            ST_UPD_DR: return m ? ST_SEL_DR : ST_IDLE;
            ST_SEL_IR: return m ? ST_RESET : ST_CAP_IR;
            ST_CAP_IR: return m ? ST_EX1_IR : ST_SH_IR;
            ST_SH_IR: return m ? ST_EX1_IR : ST_SH_IR;
            ST_EX1_IR: return m ? ST_UPD_IR : ST_PAU_IR;
            ST_PAU_IR: return m ? ST_EX2_IR : ST_PAU_IR;
            ST_EX2_IR: return m ? ST_UPD_IR : ST_SH_IR;
            ST_UPD_IR: return m ? ST_SEL_DR : ST_IDLE;
            default: return ST_RESET;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // instruction decode; pin scan falls back to bypass during configuration
    always_comb
    begin
        if (ir_reg == OPC_DEVICE_IDENTITY_REGISTER)
        begin
            sel = SEL_ID;
        end
        else if (ir_reg == OPC_USER)
        begin
            sel = SEL_USER;
        end
        else if ((ir_reg == OPC_SAMPLE || ir_reg == OPC_EXTEST) && !busy2_reg)
        begin
            sel = SEL_BSR;
        end
        else if (ir_reg == OPC_CFG)
        begin
            sel = SEL_CFG;
        end
        else if (ir_reg == OPC_ANA_RD)
        begin
            sel = SEL_ANA;
        end
        else
        begin
            sel = SEL_BYPASS;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // next values of all test clock driven state
    always_comb
    begin
        state_next = state_reg;
        ir_next = ir_reg;
        ir_sh_next = ir_sh_reg;
        dr_next = dr_reg;
        upd_next = upd_reg;
        tdo_next = tdo_reg;
        oe_next = oe_reg;
        bit_cnt_next = bit_cnt_reg;
        pend_next = pend_reg;
        overrun_next = overrun_reg;
        arm_next = 1'b0;
        // analyzer watches internal logic every system clock, not at scan speed
        ana_snap_next = ANA_PROBE;
        // hand the pending config byte to the buffer when it has room
        if (pend_reg.valid && buf_in_ready)
        begin
            pend_next.valid = 1'b0;
        end
        if (tck_rise)
        begin
            state_next = tap_step(state_reg, sync2_reg.tms);
            case (state_reg)
                ST_RESET:
                begin
                    ir_next = OPC_DEVICE_IDENTITY_REGISTER;
                end
                ST_CAP_IR:
                begin
                    ir_sh_next = `IR_CAPTURE;
                end
                ST_SH_IR:
                begin
                    ir_sh_next = {sync2_reg.tdi, ir_sh_reg[9:1]};
                end
                ST_UPD_IR:
                begin
                    ir_next = ir_sh_reg;
                    arm_next = (ir_sh_reg == OPC_ANA_ARM);
                end
                ST_CAP_DR:
                begin
                    bit_cnt_next = 3'h0;
                    dr_next = '0;
                    case (sel)
                        SEL_ID: dr_next[31:0] = ID_WORD;
                        SEL_USER: dr_next[31:0] = USER_SIG;
                        SEL_BSR: dr_next[BSR_LEN-1:0] = PIN_IN;
                        SEL_ANA: dr_next[31:0] = ana_snap_reg;
                        SEL_CFG:
                        begin
                            dr_next[`CFG_ST_READY] = !pend_reg.valid;
                            dr_next[`CFG_ST_OVERRUN] = overrun_reg;
                            overrun_next = 1'b0;
                        end
                        default: dr_next = '0;
                    endcase
                end
                ST_SH_DR:
                begin
                    // lsb leaves first, tdi enters at the top of the chosen length
                    dr_next = dr_reg >> 1;
                    case (sel)
                        SEL_ID, SEL_USER, SEL_ANA: dr_next[31] = sync2_reg.tdi;
                        SEL_BSR: dr_next[BSR_LEN-1] = sync2_reg.tdi;
                        SEL_CFG: dr_next[7] = sync2_reg.tdi;
                        default: dr_next[0] = sync2_reg.tdi;
                    endcase
                    if (sel == SEL_CFG)
                    begin
                        bit_cnt_next = bit_cnt_reg + 3'h1;
                        if (bit_cnt_reg == 3'h7)
                        begin
                            // a byte arriving on a full slot is lost and flagged
                            if (pend_next.valid)
                            begin
                                overrun_next = 1'b1;
                            end
                            else
                            begin
                                pend_next.valid = 1'b1;
                                pend_next.data = {sync2_reg.tdi, dr_reg[7:1]};
                            end
                        end
                    end
                end
                ST_UPD_DR:
                begin
                    if (sel == SEL_BSR)
                    begin
                        upd_next = dr_reg[BSR_LEN-1:0];
                    end
                end
                default:
                begin
                end
            endcase
        end
        // tdo changes only on the falling edge, one bit per shift state
        if (tck_fall)
        begin
            oe_next = (state_reg == ST_SH_IR) || (state_reg == ST_SH_DR);
            tdo_next = (state_reg == ST_SH_IR) ? ir_sh_reg[0] : dr_reg[0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register everything; reset leaves the controller in test-logic-reset
    always_ff @(posedge SYS_CLK)
    begin
        if (RESET)
        begin
            state_reg <= ST_RESET;
            ir_reg <= OPC_DEVICE_IDENTITY_REGISTER;
            ir_sh_reg <= '0;
            dr_reg <= '0;
            upd_reg <= '0;
            tdo_reg <= 1'b0;
            oe_reg <= 1'b0;
            bit_cnt_reg <= 3'h0;
            pend_reg <= '0;
            overrun_reg <= 1'b0;
            ana_snap_reg <= '0;
            arm_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            ir_reg <= ir_next;
            ir_sh_reg <= ir_sh_next;
            dr_reg <= dr_next;
            upd_reg <= upd_next;
            tdo_reg <= tdo_next;
            oe_reg <= oe_next;
            bit_cnt_reg <= bit_cnt_next;
            pend_reg <= pend_next;
            overrun_reg <= overrun_next;
            ana_snap_reg <= ana_snap_next;
            arm_reg <= arm_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // config bytes wait in a two-entry buffer and a pending slot; a byte arriving with all three full is lost and flagged
    byte_buffer #(
        .WIDTH(8)
    ) u_cfg_buf (
        .clk(SYS_CLK),
        .rst(RESET),
        .in_valid(pend_reg.valid),
        .in_data(pend_reg.data),
        .in_ready(buf_in_ready),
        .out_valid(CFG_VALID),
        .out_data(CFG_DATA),
        .out_ready(CFG_READY)
    );

    ////////////////////////////////////////////////////////////////////////
    // outputs; extest is dropped two system clocks after configuration busy rises, once it passes the two-flop sync
    assign EXTEST_EN = (ir_reg == OPC_EXTEST) && !busy2_reg;
    assign PIN_DRIVE = upd_reg;
    assign TDO = tdo_reg;
    assign TDO_OE = oe_reg;
    assign ANA_ARM = arm_reg;

endmodule

// file: src/tap_consts.svh
// constants for the boundary-scan test access port: opcodes, widths, figures
`ifndef TAP_CONSTS_SVH
`define TAP_CONSTS_SVH

// register lengths
`define IR_LEN 10
`define ID_LEN 32
`define USER_LEN 32
`define BSR_LEN_DEFAULT 1164
`define ANA_LEN 32
`define CFG_BYTE_LEN 8

// instruction opcodes (implementation choice, any unknown code selects bypass)
`define OP_EXTEST 10'h000
`define OP_CFG_LOAD 10'h002
`define OP_SAMPLE 10'h005
`define OP_DEVICE_IDENTITY_REGISTER 10'h006
`define OP_USER_SIGNATURE_REGISTER 10'h007
`define OP_ANA_READ 10'h00e
`define OP_ANA_ARM 10'h00f
`define OP_BYPASS 10'h3ff

// fixed capture pattern of the instruction path, low bits 01
`define IR_CAPTURE 10'h001

// identification word fields, values arbitrary
`define ID_VERSION 4'h1
`define ID_PART 16'h5a5a
`define ID_MAKER 11'h2aa

// config status bit positions in the captured config word
`define CFG_ST_READY 0
`define CFG_ST_OVERRUN 1

`endif

// file: src/tap_pkg.sv
// types used by the test access port; its assertion checks import them too
package tap_pkg;

    // the three sampled port inputs travel together
    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
    } jtag_in_type;

    // standard sixteen-state controller
    typedef enum logic [3:0] {
        ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PAU_DR,
        ST_EX2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR,
        ST_PAU_IR, ST_EX2_IR, ST_UPD_IR
    } tap_state_type;

    // which data register sits between the serial pins
    typedef enum logic [2:0] {
        SEL_BYPASS, SEL_ID, SEL_USER, SEL_BSR, SEL_CFG, SEL_ANA
    } dr_sel_type;

    // config byte with its handshake
    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } cfg_byte_type;

endpackage

// file: src/byte_buffer.sv
// two-entry buffer with valid/ready on both sides
`timescale 1ns/1ps
module byte_buffer #(
    parameter int WIDTH = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    logic [WIDTH-1:0] slot_reg [2];
    logic [WIDTH-1:0] slot_next [2];
    logic [1:0] count_reg;
    logic [1:0] count_next;

    ////////////////////////////////////////////////////////////////////////
    // slot 0 is always the head, so out_data comes straight from a flop
    always_comb
    begin
        logic push;
        logic pop;
        push = 1'b0;
        pop = 1'b0;
        push = in_valid && (count_reg != 2'd2);
        pop = out_ready && (count_reg != 2'd0);
        slot_next[0] = slot_reg[0];
        slot_next[1] = slot_reg[1];
        count_next = count_reg;
        if (pop)
        begin
            slot_next[0] = slot_reg[1];
        end
        if (push)
        begin
            if (count_reg == 2'd0 || (count_reg == 2'd1 && pop))
            begin
                slot_next[0] = in_data;
            end
            else
            begin
                slot_next[1] = in_data;
            end
        end
        count_next = count_reg + 2'(push) - 2'(pop);
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            count_reg <= 2'h0;
            slot_reg[0] <= '0;
            slot_reg[1] <= '0;
        end
        else
        begin
            count_reg <= count_next;
            slot_reg[0] <= slot_next[0];
            slot_reg[1] <= slot_next[1];
        end
    end

    // full refuses honestly; no fall-through, so ready never depends on out_ready
    assign in_ready = (count_reg != 2'd2);
    assign out_valid = (count_reg != 2'd0);
    assign out_data = slot_reg[0];

endmodule

// file: tb/jtag_tap_asserts.sv
// concurrent checks on the test access port outputs
`timescale 1ns/1ps
module jtag_tap_asserts
    import tap_pkg::*;
#(
    parameter int BSR_LEN = 8
) (
    input wire logic SYS_CLK,
    input wire logic RESET,
    input wire logic TDO,
    input wire logic TDO_OE,
    input wire logic CONFIG_BUSY,
    input wire logic [BSR_LEN-1:0] PIN_DRIVE,
    input wire logic EXTEST_EN,
    input wire logic [7:0] CFG_DATA,
    input wire logic CFG_VALID,
    input wire logic CFG_READY,
    input wire logic ANA_ARM
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (RESET);
    // busy must be seen through the two-flop sync before scan is refused
    sequence busy_held;
        CONFIG_BUSY [*4];
    endsequence
    sequence byte_waiting;
        CFG_VALID && !CFG_READY;
    endsequence
    ////////////////////////////////////////
    reset_idle_a: assert property ($fell(RESET) |-> !TDO_OE && !CFG_VALID && !ANA_ARM
        && !EXTEST_EN && PIN_DRIVE == '0) else $error("outputs not idle after reset");
    busy_block_a: assert property (busy_held |-> !EXTEST_EN)
        else $error("pin test enabled while busy");
    arm_pulse_a: assert property (ANA_ARM |=> !ANA_ARM)
        else $error("arm pulse too long");
    arm_quiet_a: assert property (ANA_ARM |-> !TDO_OE)
        else $error("arm pulse during shift");
    cfg_hold_a: assert property (byte_waiting |=> CFG_VALID && $stable(CFG_DATA))
        else $error("config byte lost under stall");
    cfg_take_a: assert property ($fell(CFG_VALID) |-> $past(CFG_READY))
        else $error("config byte dropped without take");
    tdo_shift_a: assert property ($changed(TDO) |-> TDO_OE || $past(TDO_OE))
        else $error("serial out moved outside shift");
    oe_stand_a: assert property ($rose(TDO_OE) |=> TDO_OE [*6])
        else $error("shift enable shorter than a test clock");
    drive_update_a: assert property ($changed(PIN_DRIVE) |-> !TDO_OE)
        else $error("pin pattern moved during shift");
endmodule

bind jtag_tap jtag_tap_asserts #(.BSR_LEN(BSR_LEN)) chk (.SYS_CLK(SYS_CLK), .RESET(RESET),
    .TDO(TDO), .TDO_OE(TDO_OE), .CONFIG_BUSY(CONFIG_BUSY), .PIN_DRIVE(PIN_DRIVE),
    .EXTEST_EN(EXTEST_EN), .CFG_DATA(CFG_DATA), .CFG_VALID(CFG_VALID),
    .CFG_READY(CFG_READY), .ANA_ARM(ANA_ARM));

// file: tb/jtag_master.sv
// behavioural serial test master that drives the port pins
`timescale 1ns/1ps
module jtag_master (
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo
);
    // test clock stands low between frames
    initial
    begin
        tck = 1'h0;
        tms = 1'h1;
        tdi = 1'h0;
    end
    ////////////////////////////////////////
    // one bit of a 64 ns link clock; pins move only while the clock is low
    task automatic bit_xfer(input logic m, input logic d, output logic q);
        tms = m;
        tdi = d;
        #32 tck = 1'h1;
        q = tdo;
        #32 tck = 1'h0;
    endtask
    // serial input is a don't-care here, so keep it toggling
    task automatic walk(input logic m);
        logic q;
        bit_xfer(m, ~tdi, q);
    endtask
    // five mode-high clocks reach reset, then park in idle
    task automatic go_reset();
        repeat (5) walk(1'h1);
        walk(1'h0);
    endtask
    // idle to shift, n bits lsb first, update, back to idle
    task automatic shift(input logic ir, input int n, input logic [31:0] d,
                         output logic [31:0] q);
        logic b;
        q = '0;
        // no extra delay: the caller starts each frame just after a system edge
        walk(1'h1);
        if (ir)
            walk(1'h1);
        walk(1'h0);
        walk(1'h0);
        for (int i = 0; i < n; i++)
        begin
            bit_xfer(i == n - 1, d[i], b);
            q[i] = b;
        end
        walk(1'h1);
        walk(1'h0);
    endtask
endmodule

// file: tb/tb.sv
// self-checking bench for the test access port
`timescale 1ns/1ps
`include "tap_consts.svh"
module tb;
    localparam int BSR = 8;
    logic sys_clk;
    logic reset;
    logic tck;
    logic tms;
    logic tdi;
    logic tdo;
    logic tdo_line;
    logic tdo_oe;
    logic config_busy;
    logic [BSR-1:0] pin_in;
    logic [BSR-1:0] pin_drive;
    logic extest_en;
    logic [31:0] user_sig;
    logic [7:0] cfg_data;
    logic cfg_valid;
    logic cfg_ready;
    logic [31:0] ana_probe;
    logic ana_arm;
    logic [15:0] lfsr_reg;
    logic [31:0] seen;
    logic [63:0] scan_q[$];
    logic [7:0] cfg_q[$];
    int fail_count;
    int num_checks;
    int arm_count;
    int cycles;
    event scan_done;

    jtag_tap #(.BSR_LEN(BSR)) dut (.SYS_CLK(sys_clk), .RESET(reset), .TCK(tck), .TMS(tms),
        .TDI(tdi), .TDO(tdo), .TDO_OE(tdo_oe), .CONFIG_BUSY(config_busy), .PIN_IN(pin_in),
        .PIN_DRIVE(pin_drive), .EXTEST_EN(extest_en), .USER_SIG(user_sig),
        .CFG_DATA(cfg_data), .CFG_VALID(cfg_valid), .CFG_READY(cfg_ready),
        .ANA_PROBE(ana_probe), .ANA_ARM(ana_arm));
    // a released serial line shows the inverse, so a stale sample cannot pass
    assign tdo_line = tdo_oe ? tdo : ~tdo;
    jtag_master link (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo_line));

    // 125 MHz system clock
    initial
    begin
        sys_clk = 1'h0;
        forever #4 sys_clk = ~sys_clk;
    end
    ////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic rnd32(output logic [31:0] v);
        lfsr_reg = lfsr_next(lfsr_reg);
        v[31:16] = lfsr_reg;
        lfsr_reg = lfsr_next(lfsr_reg);
        v[15:0] = lfsr_reg;
    endtask
    // inputs always move the same small delay after a rising edge
    task automatic tick();
        @(posedge sys_clk);
        #1;
    endtask
    // note the expected answer, then run the scan
    task automatic scan(input logic ir, input int n, input logic [31:0] d,
                        input logic [31:0] mask, input logic [31:0] exp);
        scan_q.push_back({mask, exp & mask});
        // align to a system edge so no test clock edge lands on one
        tick();
        link.shift(ir, n, d, seen);
        -> scan_done;
    endtask
    // every opcode load also checks the fixed instruction capture
    task automatic load_ir(input logic [9:0] op);
        scan(1'h1, 10, {22'h0, op}, 32'h3ff, {22'h0, `IR_CAPTURE});
    endtask
    ////////////////////////////////////////
    // scan answers against the oldest note, masked to the bits that matter
    always @(scan_done)
    begin
        logic [63:0] n;
        n = scan_q.pop_front();
        check("scan word", seen & n[63:32], n[31:0]);
    end
    // config bytes in fifo order, arm pulses, and the hang limit
    // looked at mid-cycle, where the handshake seen is the one taken next edge
    always @(negedge sys_clk)
    begin
        if (!reset && cfg_valid === 1'h1 && cfg_ready === 1'h1)
            check("config byte", {24'h0, cfg_data}, {24'h0, cfg_q.pop_front()});
        if (ana_arm === 1'h1)
            arm_count++;
        cycles++;
        if (cycles == 20000)
        begin
            fail_count++;
            wrap_up();
        end
    end
    ////////////////////////////////////////
    initial
    begin
        logic [31:0] r;
        logic [31:0] junk;
        logic [BSR-1:0] prev;
        logic [9:0] ops[3];
        reset = 1'h1;
        config_busy = 1'h0;
        pin_in = '0;
        user_sig = '0;
        cfg_ready = 1'h0;
        ana_probe = '0;
        fail_count = 0;
        num_checks = 0;
        arm_count = 0;
        cycles = 0;
        lfsr_reg = 16'h3f68;
        repeat (12) tick();
        reset = 1'h0;
        link.go_reset();
        // identity word is selected straight out of reset
        scan(1'h0, 32, 32'h0, '1, {`ID_VERSION, `ID_PART, `ID_MAKER, 1'h1});
        rnd32(r);
        tick();
        user_sig = r;
        load_ir(`OP_USER_SIGNATURE_REGISTER);
        scan(1'h0, 32, 32'h0, '1, r);
        // bypass and unknown codes give one stage that captures zero
        ops[0] = `OP_BYPASS;
        ops[1] = 10'h155;
        ops[2] = 10'h2a8;
        foreach (ops[i])
        begin
            rnd32(r);
            load_ir(ops[i]);
            scan(1'h0, 32, r, '1, {r[30:0], 1'h0});
        end
        // sample and extest, free and then while configuration is busy
        for (int k = 0; k < 4; k++)
        begin
            rnd32(r);
            tick();
            pin_in = r[7:0];
            config_busy = k[1];
            load_ir(k[0] ? `OP_EXTEST : `OP_SAMPLE);
            check("extest enable", {31'h0, extest_en}, {31'h0, k == 1});
            prev = pin_drive;
            scan(1'h0, BSR, r[31:24], 32'hff, k[1] ? {24'h0, r[30:24], 1'h0} : {24'h0, r[7:0]});
            check("pin drive", {24'h0, pin_drive}, {24'h0, k[1] ? prev : r[31:24]});
        end
        // four bytes into a stalled consumer: two buffered, one pending, one lost
        tick();
        config_busy = 1'h0;
        load_ir(`OP_CFG_LOAD);
        rnd32(r);
        link.shift(1'h0, 32, r, junk);
        cfg_q.push_back(r[7:0]);
        cfg_q.push_back(r[15:8]);
        cfg_q.push_back(r[23:16]);
        scan(1'h0, 8, 32'h0, 32'h3, 32'h2);
        repeat (40)
        begin
            tick();
            lfsr_reg = lfsr_next(lfsr_reg);
            cfg_ready = lfsr_reg[0];
        end
        tick();
        cfg_ready = 1'h1;
        repeat (4) tick();
        check("bytes left", cfg_q.size(), 32'h0);
        check("config valid", {31'h0, cfg_valid}, 32'h0);
        // analyzer: arming pulses once, reading returns the probe snapshot
        rnd32(r);
        tick();
        ana_probe = r;
        load_ir(`OP_ANA_ARM);
        check("arm pulses", arm_count, 32'h1);
        load_ir(`OP_ANA_READ);
        scan(1'h0, 32, 32'h0, '1, r);
        // mode-select reset brings the identity word back
        link.go_reset();
        scan(1'h0, 32, 32'h0, '1, {`ID_VERSION, `ID_PART, `ID_MAKER, 1'h1});
        wrap_up();
    end
endmodule
